//--- pmcg_pkg.sv
// Constants and types for the performance monitor counter group register bank.
// Assumes a 12-bit byte address within the monitor page and 32-bit data words.
package pmcg_pkg;

  // Extension presence and sizing, fixed for this build.
  localparam logic      EXT_PRESENT        = 1'b1;
  localparam logic      EXPORT_SUPPORTED   = 1'b1;
  localparam int        NUM_COUNTERS       = 8;
  localparam int        NUM_GROUPS         = 2;
  localparam int        COUNTERS_PER_GROUP = 4;
  localparam int        SID_BITS           = 10;
  localparam int        CNT_WIDTH          = 32;

  // Byte offsets inside the monitor page.
  localparam logic [11:0] OFF_GROUP_CFG     = 12'h800;
  localparam logic [11:0] OFF_STREAM_MATCH  = 12'ha00;
  localparam logic [11:0] OFF_CNT_EN_SET    = 12'hc00;
  localparam logic [11:0] OFF_CNT_EN_CLR    = 12'hc20;
  localparam logic [11:0] OFF_CONFIG        = 12'he00;
  localparam logic [11:0] OFF_CONTROL       = 12'he04;
  localparam logic [11:0] OFF_EVENT_ID_HIGH = 12'he24;

  // Field positions of the configuration register.
  localparam int CFG_GROUP_COUNT_LSB = 24;
  localparam int CFG_UNPRIV_BIT      = 19;
  localparam int CFG_EXPORT_CAP_BIT  = 16;
  localparam int CFG_PRESCALE_BIT    = 15;
  localparam int CFG_CYCLE_CTR_BIT   = 14;
  localparam int CFG_SIZE_LSB        = 8;
  localparam int CFG_NUM_CTR_LSB     = 0;
  localparam logic [5:0] CFG_SIZE_32BIT = 6'h1f;

  // Field positions of the group configuration register.
  localparam int GCR_COUNTERS_LSB = 24;
  localparam int GCR_STREAM_G_LSB = 16;
  localparam int GCR_EXPORT_BIT   = 12;
  localparam int GCR_COUNT_EN_BIT = 11;
  localparam int GCR_BANK_EN_BIT  = 10;
  localparam int GCR_FILTER_LSB   = 8;
  localparam int GCR_INDEX_LSB    = 0;

  // Field positions of the stream match register.
  localparam int SMR_MASK_LSB = 16;
  localparam int SMR_ID_LSB   = 0;

  // Field positions of the control register.
  localparam int CTL_IMP_LSB    = 24;
  localparam int CTL_EXPORT_BIT = 4;
  localparam int CTL_RESET_BIT  = 1;
  localparam int CTL_ENABLE_BIT = 0;

  // Implementer code, an arbitrary neutral value.
  localparam logic [7:0] CTL_IMP_CODE = 8'h00;

  // Reset values; the architectural reset value is unknown, zero is chosen.
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    PMCG_FILTER_GLOBAL,
    PMCG_FILTER_STREAM,
    PMCG_FILTER_BANK,
    PMCG_FILTER_RSVD
  } pmcg_filter_t;

endpackage

//--- pmcg_count_if.sv
// Interface carrying the per-counter count strobes and the reset-all pulse.
// Assumes both ends run on the same clock.
interface pmcg_count_if;
  logic [pmcg_pkg::NUM_COUNTERS-1:0] count_now;
  logic                              clear_all;
  modport ctl  (output count_now, output clear_all);
  modport bank (input count_now, input clear_all);
endinterface

//--- pmcg_counter_bank.sv
// Event counter storage for the counter group register bank.
// Assumes the control side gates count_now and issues clear_all as a pulse.
module pmcg_counter_bank (
  input  wire logic                                             clk,
  input  wire logic                                             reset_n,
  pmcg_count_if.bank                                            cnt,
  output logic [pmcg_pkg::NUM_COUNTERS*pmcg_pkg::CNT_WIDTH-1:0] counter_values
);
  import pmcg_pkg::*;

  logic [CNT_WIDTH-1:0] counter [NUM_COUNTERS];

  always_ff @(posedge clk) begin
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (!reset_n) begin
        counter[i] <= RESET_WORD;
      end else if (cnt.clear_all) begin
        counter[i] <= RESET_WORD;
      end else if (cnt.count_now[i]) begin
        counter[i] <= counter[i] + 32'h0000_0001;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      counter_values[i*CNT_WIDTH +: CNT_WIDTH] = counter[i];
    end
  end

endmodule

//--- pmcg_regbank.sv
// Register bank for the counter group configuration and count enable control.
// Assumes a single-cycle strobe register port and events synchronous to clk.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
module pmcg_regbank (
  input  wire logic                                             clk,
  input  wire logic                                             reset_n,
  input  wire logic [11:0]                                      reg_addr,
  input  wire logic [31:0]                                      reg_wdata,
  input  wire logic                                             reg_write,
  input  wire logic                                             reg_read,
  output logic [31:0]                                           reg_rdata,
  input  wire logic [pmcg_pkg::NUM_COUNTERS-1:0]                event_pulse,
  input  wire logic [14:0]                                      event_stream_id,
  input  wire logic [7:0]                                       event_bank,
  output logic [pmcg_pkg::NUM_COUNTERS*pmcg_pkg::CNT_WIDTH-1:0] counter_values,
  output logic                                                  export_enable,
  output logic [pmcg_pkg::NUM_GROUPS-1:0]                       group_visible,
  output logic [pmcg_pkg::NUM_GROUPS*8-1:0]                     group_bank_index
);
  import pmcg_pkg::*;

  localparam logic [NUM_COUNTERS-1:0] CNT_IMPL_MASK = '1;

  pmcg_count_if cnt_if ();

  // Stored control state.
  logic                    global_enable;
  logic [NUM_COUNTERS-1:0] cnt_enable;
  logic [NUM_GROUPS-1:0]   grp_export;
  logic [NUM_GROUPS-1:0]   grp_count_en;
  logic [NUM_GROUPS-1:0]   grp_bank_en;
  logic [1:0]              grp_filter [NUM_GROUPS];
  logic [7:0]              grp_index  [NUM_GROUPS];
  logic [SID_BITS-1:0]     sm_mask    [NUM_GROUPS];
  logic [SID_BITS-1:0]     sm_id      [NUM_GROUPS];

  function automatic logic stream_hit(input logic [14:0]         sid,
                                      input logic [SID_BITS-1:0] id,
                                      input logic [SID_BITS-1:0] mask);
    stream_hit = ((sid[SID_BITS-1:0] ^ id) & ~mask) == '0;
  endfunction

  function automatic logic filter_pass(input logic [1:0] mode,
                                       input logic       hit,
                                       input logic [7:0] bank,
                                       input logic [7:0] index);
    case (pmcg_filter_t'(mode))
      PMCG_FILTER_GLOBAL: filter_pass = 1'b1;
      PMCG_FILTER_STREAM: filter_pass = hit;
      PMCG_FILTER_BANK:   filter_pass = (bank == index);
      default:            filter_pass = 1'b0;
    endcase
  endfunction

  // Address decode.
  wire logic       aligned      = (reg_addr[1:0] == 2'b00);
  wire logic [6:0] word_index   = reg_addr[8:2];
  wire logic [2:0] enable_index = reg_addr[4:2];
  wire logic       grp_in_range = (word_index < 7'(NUM_GROUPS));
  wire logic       hit_grp_cfg  = aligned && (reg_addr[11:9] == OFF_GROUP_CFG[11:9]);
  wire logic       hit_sm       = aligned && (reg_addr[11:9] == OFF_STREAM_MATCH[11:9]);
  wire logic       hit_en_set   = aligned && (reg_addr[11:5] == OFF_CNT_EN_SET[11:5]);
  wire logic       hit_en_clr   = aligned && (reg_addr[11:5] == OFF_CNT_EN_CLR[11:5]);
  wire logic       hit_config   = (reg_addr == OFF_CONFIG);
  wire logic       hit_control  = (reg_addr == OFF_CONTROL);
  wire logic       hit_id_high  = (reg_addr == OFF_EVENT_ID_HIGH);
  wire logic       enable_word0 = (enable_index == 3'h0);

  wire logic wr_ok      = reg_write && EXT_PRESENT;
  wire logic wr_grp_cfg = wr_ok && hit_grp_cfg && grp_in_range;
  wire logic wr_sm      = wr_ok && hit_sm && grp_in_range;
  wire logic wr_control = wr_ok && hit_control;

  wire logic [NUM_COUNTERS-1:0] set_bits =
    (wr_ok && hit_en_set && enable_word0) ? reg_wdata[NUM_COUNTERS-1:0] : '0;
  wire logic [NUM_COUNTERS-1:0] clr_bits =
    (wr_ok && hit_en_clr && enable_word0) ? reg_wdata[NUM_COUNTERS-1:0] : '0;
  wire logic [NUM_COUNTERS-1:0] next_cnt_enable =
    ((cnt_enable | set_bits) & ~clr_bits) & CNT_IMPL_MASK;

  // export bit writable only when supported.
  wire logic next_export =
    wr_control ? (reg_wdata[CTL_EXPORT_BIT] & EXPORT_SUPPORTED) : export_enable;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      global_enable <= 1'b0;
      export_enable <= 1'b0;
      cnt_enable    <= '0;
    end else begin
      if (wr_control) begin
        global_enable <= reg_wdata[CTL_ENABLE_BIT];
      end
      export_enable <= next_export;
      cnt_enable    <= next_cnt_enable;
    end
  end

  always_ff @(posedge clk) begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      if (!reset_n) begin
        grp_export[g]   <= 1'b0;
        grp_count_en[g] <= 1'b0;
        grp_bank_en[g]  <= 1'b0;
        grp_filter[g]   <= 2'h0;
        grp_index[g]    <= 8'h00;
        sm_mask[g]      <= '0;
        sm_id[g]        <= '0;
      end else begin
        if (wr_grp_cfg && (word_index == 7'(g))) begin
          grp_export[g]   <= reg_wdata[GCR_EXPORT_BIT];
          grp_count_en[g] <= reg_wdata[GCR_COUNT_EN_BIT];
          grp_bank_en[g]  <= reg_wdata[GCR_BANK_EN_BIT];
          grp_filter[g]   <= reg_wdata[GCR_FILTER_LSB +: 2];
          grp_index[g]    <= reg_wdata[GCR_INDEX_LSB +: 8];
        end
        if (wr_sm && (word_index == 7'(g))) begin
          sm_mask[g] <= reg_wdata[SMR_MASK_LSB +: SID_BITS];
          sm_id[g]   <= reg_wdata[SMR_ID_LSB +: SID_BITS];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      group_visible    <= '0;
      group_bank_index <= '0;
    end else begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        group_visible[g]        <= grp_bank_en[g];
        group_bank_index[g*8 +: 8] <= grp_index[g];
      end
    end
  end

  // Filter result per group.
  logic [NUM_GROUPS-1:0] group_pass;
  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      group_pass[g] = filter_pass(grp_filter[g],
                                  stream_hit(event_stream_id, sm_id[g], sm_mask[g]),
                                  event_bank, grp_index[g]);
    end
  end

  // counting needs the global, counter and group count enables and the group filter.
  always_comb begin
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      cnt_if.count_now[i] = event_pulse[i] && global_enable && cnt_enable[i]
                            && grp_count_en[i / COUNTERS_PER_GROUP]
                            && group_pass[i / COUNTERS_PER_GROUP];
    end
  end

  assign cnt_if.clear_all = wr_control && reg_wdata[CTL_RESET_BIT];

  pmcg_counter_bank u_counters (
    .clk            (clk),
    .reset_n        (reset_n),
    .cnt            (cnt_if),
    .counter_values (counter_values)
  );

  // Read word assembly.
  wire logic [31:0] config_word =
    (32'(NUM_GROUPS - 1) << CFG_GROUP_COUNT_LSB)
    | (32'h0 << CFG_UNPRIV_BIT)
    | (32'h0 << CFG_PRESCALE_BIT)
    | (32'h0 << CFG_CYCLE_CTR_BIT)
    | (32'(EXPORT_SUPPORTED) << CFG_EXPORT_CAP_BIT)
    | (32'(CFG_SIZE_32BIT) << CFG_SIZE_LSB)
    | (32'(NUM_COUNTERS - 1) << CFG_NUM_CTR_LSB);

  // The reset bit is write-only, so it never reads back.
  wire logic [31:0] control_word =
    (32'(CTL_IMP_CODE) << CTL_IMP_LSB)
    | (32'(export_enable) << CTL_EXPORT_BIT)
    | (32'(global_enable) << CTL_ENABLE_BIT);

  wire logic [6:0] grp_sel = grp_in_range ? word_index : 7'h00;

  wire logic [31:0] group_word =
    (32'(COUNTERS_PER_GROUP) << GCR_COUNTERS_LSB)
    | (32'(grp_sel) << GCR_STREAM_G_LSB)
    | (32'(grp_export[grp_sel[0]]) << GCR_EXPORT_BIT)
    | (32'(grp_count_en[grp_sel[0]]) << GCR_COUNT_EN_BIT)
    | (32'(grp_bank_en[grp_sel[0]]) << GCR_BANK_EN_BIT)
    | (32'(grp_filter[grp_sel[0]]) << GCR_FILTER_LSB)
    | (32'(grp_index[grp_sel[0]]) << GCR_INDEX_LSB);

  wire logic [31:0] match_word =
    (32'(sm_mask[grp_sel[0]]) << SMR_MASK_LSB)
    | (32'(sm_id[grp_sel[0]]) << SMR_ID_LSB);

  wire logic [31:0] enable_word = enable_word0 ? 32'(cnt_enable) : 32'h0000_0000;

  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_config) begin
      next_rdata = config_word;
    end else if (hit_control) begin
      next_rdata = control_word;
    end else if (hit_grp_cfg && grp_in_range) begin
      next_rdata = group_word;
    end else if (hit_sm && grp_in_range) begin
      next_rdata = match_word;
    end else if (hit_en_set || hit_en_clr) begin
      next_rdata = enable_word;
    end else if (hit_id_high) begin
      next_rdata = 32'h0000_0000;
    end
  end

  // Read data is held only for the cycle after the strobe, as the master expects.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read && EXT_PRESENT) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

//--- pmcg_regbank_monitor.sv
// Concurrent checks on the ports of the counter group register bank.
// Assumes one clock, synchronous active-low reset and the strobe register port.
module pmcg_regbank_monitor
  import pmcg_pkg::*;
(
  input wire logic                                   clk,
  input wire logic                                   reset_n,
  input wire logic [11:0]                            reg_addr,
  input wire logic [31:0]                            reg_wdata,
  input wire logic                                   reg_write,
  input wire logic                                   reg_read,
  input wire logic [31:0]                            reg_rdata,
  input wire logic [NUM_COUNTERS-1:0]                event_pulse,
  input wire logic [14:0]                            event_stream_id,
  input wire logic [7:0]                             event_bank,
  input wire logic [NUM_COUNTERS*CNT_WIDTH-1:0]      counter_values,
  input wire logic                                   export_enable,
  input wire logic [NUM_GROUPS-1:0]                  group_visible,
  input wire logic [NUM_GROUPS*8-1:0]                group_bank_index
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_wr(logic [11:0] a);
    reg_write && reg_addr == a;
  endsequence
  sequence s_rd(logic [11:0] a);
    reg_read && reg_addr == a;
  endsequence
  // Two-step sequence: a write left alone for one cycle.
  sequence s_wr_quiet(logic [11:0] a);
    s_wr(a) ##1 !(reg_write && reg_addr == a);
  endsequence

  a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  a_config_word: assert property (s_rd(OFF_CONFIG) |=> reg_rdata == 32'h0101_1f07)
    else $error("configuration word wrong");
  a_event_id_high: assert property (s_rd(OFF_EVENT_ID_HIGH) |=> reg_rdata == 32'h0)
    else $error("event id high word not zero");
  a_enable_spare: assert property (
    s_rd(OFF_CNT_EN_SET) or s_rd(OFF_CNT_EN_CLR)
    |=> reg_rdata[31:NUM_COUNTERS] == '0)
    else $error("spare enable bits not zero");
  a_set_readback: assert property (
    s_wr(OFF_CNT_EN_SET) ##1 s_rd(OFF_CNT_EN_SET)
    |=> (reg_rdata & $past(reg_wdata, 2) & 32'h0000_00ff)
        == ($past(reg_wdata, 2) & 32'h0000_00ff))
    else $error("set write did not enable");
  a_clear_readback: assert property (
    s_wr(OFF_CNT_EN_CLR) ##1 s_rd(OFF_CNT_EN_SET)
    |=> (reg_rdata & $past(reg_wdata, 2)) == 32'h0)
    else $error("clear write did not disable");
  a_counter_reset: assert property (
    reg_write && reg_addr == OFF_CONTROL && reg_wdata[CTL_RESET_BIT]
    |=> counter_values == '0)
    else $error("counter reset did not clear");
  a_counters_hold: assert property (
    event_pulse == '0 && !(reg_write && reg_addr == OFF_CONTROL)
    |=> $stable(counter_values))
    else $error("counter moved without an event");
  a_export_follow: assert property (
    s_wr_quiet(OFF_CONTROL)
    |=> export_enable == $past(reg_wdata[CTL_EXPORT_BIT], 2))
    else $error("export enable does not follow control");
  a_visible_lag: assert property (
    s_wr_quiet(OFF_GROUP_CFG + 12'h004)
    |=> group_visible[1] == $past(reg_wdata[GCR_BANK_EN_BIT], 2)
        && group_bank_index[15:8] == $past(reg_wdata[7:0], 2))
    else $error("group visibility or index wrong");
endmodule

bind pmcg_regbank pmcg_regbank_monitor u_mon (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .event_pulse(event_pulse), .event_stream_id(event_stream_id), .event_bank(event_bank),
  .counter_values(counter_values), .export_enable(export_enable),
  .group_visible(group_visible), .group_bank_index(group_bank_index)
);

//--- tb_pmcg_regbank.sv
// Self-checking bench for the counter group register bank.
// Assumes the bound checker and a 100 MHz clock driven here.
module tb_pmcg_regbank;
  timeunit 1ns;
  timeprecision 100ps;
  import pmcg_pkg::*;

  logic         clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, export_enable;
  logic [11:0]  reg_addr = '0;
  logic [31:0]  reg_wdata = '0, reg_rdata;
  logic [7:0]   event_pulse = '0, event_bank = '0;
  logic [14:0]  event_stream_id = '0;
  logic [255:0] counter_values;
  logic [1:0]   group_visible;
  logic [15:0]  group_bank_index;
  int           n_mismatch = 0, compares = 0;

  pmcg_regbank uut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .event_pulse(event_pulse), .event_stream_id(event_stream_id), .event_bank(event_bank),
    .counter_values(counter_values), .export_enable(export_enable),
    .group_visible(group_visible), .group_bank_index(group_bank_index)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    #1;
  endtask

  // The answer stands only in the cycle after the strobe, so it is taken there.
  task rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  // A write with the read strobe right behind it, no idle cycle between.
  task wr_rd(input logic [11:0] wa, input logic [31:0] wd,
             input logic [11:0] ra, input logic [31:0] e);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= wa;
    reg_wdata <= wd;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    reg_addr  <= ra;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task pulse(input logic [7:0] p);
    @(posedge clk);
    event_pulse <= p;
    @(posedge clk);
    event_pulse <= '0;
    #1;
  endtask

  function automatic logic [31:0] cnt(input int i);
    return counter_values[32*i +: 32];
  endfunction

  task t_identity;
    rd(OFF_CONFIG, 32'h0101_1f07);
    rd(OFF_EVENT_ID_HIGH, 32'h0);
    rd(OFF_GROUP_CFG, 32'h0400_0000);
    rd(OFF_GROUP_CFG + 12'h004, 32'h0401_0000);
    rd(12'he08, 32'h0);
    $display("identity test done");
  endtask

  task t_fields;
    wr(OFF_GROUP_CFG, 32'hffff_fdff);
    rd(OFF_GROUP_CFG, 32'h0400_1dff);
    wr(OFF_GROUP_CFG, 32'h0);
    wr(OFF_STREAM_MATCH, 32'hffff_ffff);
    rd(OFF_STREAM_MATCH, 32'h03ff_03ff);
    $display("field test done");
  endtask

  task t_enables;
    wr_rd(OFF_CNT_EN_SET, 32'h0000_00a5, OFF_CNT_EN_SET, 32'h0000_00a5);
    rd(OFF_CNT_EN_CLR, 32'h0000_00a5);
    wr_rd(OFF_CNT_EN_CLR, 32'h0000_0005, OFF_CNT_EN_SET, 32'h0000_00a0);
    wr(OFF_CNT_EN_SET, 32'hffff_ffff);
    rd(OFF_CNT_EN_CLR, 32'h0000_00ff);
    wr(OFF_CNT_EN_SET + 12'h004, 32'hffff_ffff);
    rd(OFF_CNT_EN_SET + 12'h004, 32'h0);
    $display("enable test done");
  endtask

  task t_count;
    wr(OFF_GROUP_CFG, 32'h0000_0800);
    wr(OFF_CONTROL, 32'h1);
    pulse(8'h01);
    chk(cnt(0), 32'd1);
    wr(OFF_CONTROL, 32'h0);
    pulse(8'h01);
    chk(cnt(0), 32'd1);
    rd(OFF_CNT_EN_SET, 32'h0000_00ff);
    wr(OFF_CONTROL, 32'h1);
    wr(OFF_CNT_EN_CLR, 32'h0000_0002);
    pulse(8'h03);
    chk(cnt(1), 32'd0);
    chk(cnt(0), 32'd2);
    wr(OFF_STREAM_MATCH + 12'h004, 32'h0000_0005);
    wr(OFF_GROUP_CFG + 12'h004, 32'h0000_0900);
    @(posedge clk) event_stream_id <= 15'h005;
    pulse(8'h10);
    chk(cnt(4), 32'd1);
    @(posedge clk) event_stream_id <= 15'h007;
    pulse(8'h10);
    chk(cnt(4), 32'd1);
    wr(OFF_STREAM_MATCH + 12'h004, 32'h0002_0005);
    pulse(8'h10);
    chk(cnt(4), 32'd2);
    wr(OFF_GROUP_CFG + 12'h004, 32'h0000_0e07);
    @(posedge clk) event_bank <= 8'h07;
    pulse(8'h10);
    chk(cnt(4), 32'd3);
    @(posedge clk) event_bank <= 8'h03;
    pulse(8'h10);
    chk(cnt(4), 32'd3);
    chk({30'd0, group_visible}, 32'h2);
    chk({24'd0, group_bank_index[15:8]}, 32'h07);
    wr(OFF_GROUP_CFG + 12'h004, 32'h0000_0b00);
    pulse(8'h10);
    chk(cnt(4), 32'd3);
    wr(OFF_GROUP_CFG + 12'h004, 32'h0);
    pulse(8'h10);
    chk(cnt(4), 32'd3);
    $display("count test done");
  endtask

  task t_control;
    wr(OFF_CONTROL, 32'h0000_0013);
    chk(cnt(0), 32'd0);
    chk(cnt(4), 32'd0);
    rd(OFF_CONTROL, 32'h0000_0011);
    chk({31'd0, export_enable}, 32'h1);
    $display("control test done");
  endtask

  task results;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_identity;
    t_fields;
    t_enables;
    t_count;
    t_control;
    results;
  end

  // The tests take well under a thousand cycles; this limit is ample.
  initial begin
    #50000;
    n_mismatch++;
    results;
  end
endmodule
